// ---- icc_cfg.svh ----
// constants, register map and mode codes of the input capture channel
//
// Contract
// RULE1: enable bit 15 clear resets channel, stops clocks, blocks interrupts.
// RULE2: idle_stop bit 13 set halts the channel while cpu is idle.
// RULE3: first_edge_select bit 9 picks first edge, only in mode 110.
// RULE4: wide_capture_select bit 8 picks 32-bit or 16-bit capture.
// RULE5: timer_source_select bit 7 picks third (0) or second (1) timer, ignored at 32-bit.
// RULE6: interrupt_every_n 11/10/01/00 interrupts every 4th/3rd/2nd/2nd capture.
// RULE7: capture_overrun_flag bit 4 is read-only, set after overflow.
// RULE8: buffer_nonempty_flag bit 3 is read-only, set while data remains.
// RULE9: capture_mode_field bits 2..0; 110 is mode 6.
// RULE10: bits 31..16, 14, 12..10 of control read zero.
// RULE11: software avoids access in the cycle after clearing enable.
// RULE12: qualifying edge stores timer value; capture into full buffer is overflow.
`ifndef ICC_CFG_SVH
`define ICC_CFG_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ICC_ADDR_W        4
`define ICC_OFF_CTRL      4'h0
`define ICC_OFF_BUF       4'h4
`define ICC_OFF_STAT      4'h8
`define ICC_OFF_MASK      4'hc

// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define ICC_B_ON          15
`define ICC_B_IDLE        13
`define ICC_B_FIRST_EDGE  9
`define ICC_B_WIDE        8
`define ICC_B_TSEL        7
`define ICC_B_IRH         6
`define ICC_B_IRL         5
`define ICC_B_OVF         4
`define ICC_B_BNE         3
`define ICC_B_MH          2
`define ICC_CTRL_WMASK    32'h0000_a3e7
`define ICC_CTRL_RST      32'h0000_0000

// ---------------------------------------------------------------
// modes and sizes
// ---------------------------------------------------------------
`define ICC_M_OFF         3'h0
`define ICC_M_EVERY       3'h1
`define ICC_M_FALL        3'h2
`define ICC_M_RISE        3'h3
`define ICC_M_RISE4       3'h4
`define ICC_M_RISE16      3'h5
`define ICC_M_FIRST       3'h6
`define ICC_M_WAKE        3'h7
`define ICC_DEPTH         4
`define ICC_PTR_W         2
`define ICC_CNT_W         3
`define ICC_PRE_W         4
`define ICC_PRE4          2'h3
`define ICC_PRE16         4'hf
`define ICC_EV_CAP        0
`define ICC_EV_OVF        1
`define ICC_EV_W          2

`endif

// ---- icc_pkg.sv ----
// types of the input capture channel
package icc_pkg;
  typedef enum logic [1:0] {
    ICC_ST_OFF,
    ICC_ST_FIRST,
    ICC_ST_RUN
  } icc_state_t;
endpackage

// ---- icc_edge.sv ----
// synchroniser and edge detector of the capture pin
`timescale 1ns/1ps
module icc_edge (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // two-flop sync, third flop for history
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign level_o = s2_reg;
  assign rise_o  = s2_reg & ~s3_reg;
  assign fall_o  = ~s2_reg & s3_reg;
endmodule

// ---- icc_top.sv ----
// input capture channel: control register, capture buffer, interrupt
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "icc_cfg.svh"
module icc_top (
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_i,
  input  wire logic                   cap_pin_i,
  input  wire logic                   cpu_idle_i,
  input  wire logic [31:0]            third_timer_source_i,
  input  wire logic [31:0]            second_timer_source_i,
  input  wire logic [31:0]            wide_timer_i,
  input  wire logic [`ICC_ADDR_W-1:0] addr_i,
  input  wire logic [31:0]            wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [31:0]            rdata_o,
  output logic                        irq_o
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [31:0]              ctrl_reg;
  logic [31:0]              fifo_mem [`ICC_DEPTH];
  logic [`ICC_PTR_W-1:0]    wptr_reg;
  logic [`ICC_PTR_W-1:0]    rptr_reg;
  logic [`ICC_CNT_W-1:0]    cnt_reg;
  logic                     ovf_reg;
  logic [`ICC_PRE_W-1:0]    pre_reg;
  logic [1:0]               evn_reg;
  logic [`ICC_EV_W-1:0]     stat_reg;
  logic [`ICC_EV_W-1:0]     mask_reg;
  logic [31:0]              rdata_reg;
  logic                     irq_reg;
  icc_pkg::icc_state_t      state_reg;
  icc_pkg::icc_state_t      state_next;
  logic                     pin_lvl;
  logic                     pin_rise;
  logic                     pin_fall;

  // ---------------------------------------------------------------
  // pin edge detection
  // ---------------------------------------------------------------
  icc_edge u_edge (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .pin_i     (cap_pin_i),
    .level_o   (pin_lvl),
    .rise_o    (pin_rise),
    .fall_o    (pin_fall)
  );

  // ---------------------------------------------------------------
  // control field decode
  // ---------------------------------------------------------------
  wire       on_w    = ctrl_reg[`ICC_B_ON];
  wire       idle_w  = ctrl_reg[`ICC_B_IDLE];
  wire       first_edge_w = ctrl_reg[`ICC_B_FIRST_EDGE];
  wire       wide_w  = ctrl_reg[`ICC_B_WIDE];
  wire       tsel_w  = ctrl_reg[`ICC_B_TSEL];
  wire [1:0] rate_w  = ctrl_reg[`ICC_B_IRH:`ICC_B_IRL];
  wire [2:0] mode_w  = ctrl_reg[`ICC_B_MH:0];

  // channel running: on, and not halted by cpu idle
  wire run_w = on_w & ~(idle_w & cpu_idle_i); // see RULE1 see RULE2

  // ---------------------------------------------------------------
  // register bus decode
  // ---------------------------------------------------------------
  wire sel_ctrl = (addr_i == `ICC_OFF_CTRL);
  wire sel_buf  = (addr_i == `ICC_OFF_BUF);
  wire sel_stat = (addr_i == `ICC_OFF_STAT);
  wire sel_mask = (addr_i == `ICC_OFF_MASK);
  wire wr_ctrl  = wr_i & sel_ctrl;
  wire pop_w    = rd_i & sel_buf & (cnt_reg != '0);

  // ---------------------------------------------------------------
  // timer source and edge qualification
  // ---------------------------------------------------------------
  wire [31:0] tsel16_w  = tsel_w ? second_timer_source_i : third_timer_source_i; // see RULE5
  wire [31:0] tval_w    = wide_w ? wide_timer_i : {16'h0000, tsel16_w[15:0]}; // see RULE4
  wire        any_edge  = pin_rise | pin_fall;
  wire        first_hit = first_edge_w ? pin_rise : pin_fall; // see RULE3
  // low two bits only, so mode 4 repeats every fourth rise, not every sixteenth
  wire        pre_end4  = (pre_reg[1:0] == `ICC_PRE4);
  wire        pre_end16 = (pre_reg == `ICC_PRE16);

  // one flat selection of the qualifying edge per mode
  wire qual_w =
    (mode_w == `ICC_M_EVERY)  ? any_edge :
    (mode_w == `ICC_M_FALL)   ? pin_fall :
    (mode_w == `ICC_M_RISE)   ? pin_rise :
    (mode_w == `ICC_M_RISE4)  ? (pin_rise & pre_end4) :
    (mode_w == `ICC_M_RISE16) ? (pin_rise & pre_end16) :
    (mode_w == `ICC_M_FIRST)  ? ((state_reg == icc_pkg::ICC_ST_FIRST) ? first_hit : any_edge) : // see RULE9
    1'b0;

  wire cap_w  = run_w & qual_w; // see RULE12
  wire full_w = (cnt_reg == `ICC_CNT_W'(`ICC_DEPTH));
  wire push_w = cap_w & ~full_w;
  wire ovf_ev = cap_w & full_w; // see RULE12

  // interrupt cadence: 00 and 01 every second, 10 third, 11 fourth
  wire [1:0] n_last = (rate_w == 2'h3) ? 2'h3 : (rate_w == 2'h2) ? 2'h2 : 2'h1; // see RULE6
  wire       cap_ev = push_w & (evn_reg == n_last);

  // ---------------------------------------------------------------
  // first-edge state machine
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      icc_pkg::ICC_ST_OFF: begin
        if (on_w) begin
          state_next = icc_pkg::ICC_ST_FIRST;
        end
      end
      icc_pkg::ICC_ST_FIRST: begin
        if (cap_w) begin
          state_next = icc_pkg::ICC_ST_RUN;
        end
      end
      default: begin
        state_next = state_reg;
      end
    endcase
    if (!on_w) begin
      state_next = icc_pkg::ICC_ST_OFF; // see RULE1
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= icc_pkg::ICC_ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // control register, writable only where implemented
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= `ICC_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= wdata_i & `ICC_CTRL_WMASK; // see RULE10
    end
  end

  // ---------------------------------------------------------------
  // capture buffer
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `ICC_DEPTH; gi++) begin : g_mem
      always_ff @(posedge clk_sys_i) begin
        if (push_w && wptr_reg == `ICC_PTR_W'(gi)) begin
          fifo_mem[gi] <= tval_w; // see RULE12
        end
      end
    end
  endgenerate

  // pointers, level and overflow; all cleared while disabled
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
      ovf_reg  <= 1'b0;
    end else if (!on_w) begin
      wptr_reg <= '0; // see RULE1
      rptr_reg <= '0;
      cnt_reg  <= '0;
      ovf_reg  <= 1'b0;
    end else begin
      wptr_reg <= wptr_reg + `ICC_PTR_W'(push_w);
      rptr_reg <= rptr_reg + `ICC_PTR_W'(pop_w);
      cnt_reg  <= cnt_reg + `ICC_CNT_W'(push_w) - `ICC_CNT_W'(pop_w);
      ovf_reg  <= ovf_reg | ovf_ev; // see RULE7
    end
  end

  // ---------------------------------------------------------------
  // prescaler and interrupt event counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pre_reg <= '0;
      evn_reg <= '0;
    end else if (!on_w) begin
      pre_reg <= '0;
      evn_reg <= '0;
    end else begin
      if (run_w && pin_rise) begin
        pre_reg <= pre_reg + `ICC_PRE_W'(1);
      end
      if (push_w) begin
        evn_reg <= (evn_reg == n_last) ? 2'h0 : evn_reg + 2'h1; // see RULE6
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, mask and output
  // ---------------------------------------------------------------
  wire [`ICC_EV_W-1:0] ev_w  = {ovf_ev, cap_ev};
  wire [`ICC_EV_W-1:0] clr_w = (wr_i && sel_stat) ? wdata_i[`ICC_EV_W-1:0] : '0;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      stat_reg <= '0;
      mask_reg <= '0;
      irq_reg  <= 1'b0;
    end else begin
      stat_reg <= on_w ? ((stat_reg & ~clr_w) | ev_w) : '0; // set wins over clear, see RULE1
      if (wr_i && sel_mask) begin
        mask_reg <= wdata_i[`ICC_EV_W-1:0];
      end
      irq_reg  <= on_w & |(stat_reg & mask_reg); // see RULE1
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  wire [31:0] ctrl_rd = (ctrl_reg & `ICC_CTRL_WMASK)
                      | (32'(ovf_reg) << `ICC_B_OVF)               // see RULE7
                      | (32'(cnt_reg != '0) << `ICC_B_BNE);        // see RULE8
  wire [31:0] rd_mux =
    sel_ctrl ? ctrl_rd :
    sel_buf  ? ((cnt_reg != '0) ? fifo_mem[rptr_reg] : 32'h0000_0000) :
    sel_stat ? 32'({pin_lvl, stat_reg}) :
    sel_mask ? 32'(mask_reg) :
    32'h0000_0000;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rd_i ? rd_mux : 32'h0000_0000;
    end
  end

  assign rdata_o = rdata_reg;
  assign irq_o   = irq_reg;
endmodule

// ---- icc_pin_model.sv ----
// external signal source driving the capture pin
`timescale 1ns/1ps
module icc_pin_model (
  input  wire logic clk_sys_i,
  output logic      pin_o
);
  initial pin_o = 1'b0;
  // move the pin just after an edge; it stays put between commands
  task automatic set_level(input logic v);
    @(posedge clk_sys_i);
    pin_o <= v;
  endtask
endmodule

// ---- icc_top_checker.sv ----
// port assertions of the input capture channel
`timescale 1ns/1ps
`include "icc_cfg.svh"
module icc_top_checker (
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic [3:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        irq_o
);
  logic [31:0] ctl_reg, ctq_reg;
  logic [1:0]  msk_reg;
  logic        rdq_reg, rdc_reg, rdb_reg;
  // mirror of software writes and of the read just issued
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_reg <= 32'h0;
      ctq_reg <= 32'h0;
      msk_reg <= 2'h0;
      rdq_reg <= 1'b0;
      rdc_reg <= 1'b0;
      rdb_reg <= 1'b0;
    end else begin
      if (wr_i && addr_i == `ICC_OFF_CTRL) ctl_reg <= wdata_i;
      if (wr_i && addr_i == `ICC_OFF_MASK) msk_reg <= wdata_i[1:0];
      ctq_reg <= ctl_reg;
      rdq_reg <= rd_i;
      rdc_reg <= rd_i && addr_i == `ICC_OFF_CTRL;
      rdb_reg <= rd_i && addr_i == `ICC_OFF_BUF;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_quiet; !rdq_reg |-> rdata_o == 32'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("read data outside a read");
  property p_unimpl; rdc_reg |-> (rdata_o & 32'hffff_5c00) == 32'h0; endproperty
  a_unimpl: assert property (p_unimpl) else $error("unused control bits set");
  property p_fields; rdc_reg |-> rdata_o[9:5] == ctq_reg[9:5]; endproperty
  a_fields: assert property (p_fields) else $error("control field readback");
  property p_mode; rdc_reg |-> {rdata_o[15], rdata_o[13], rdata_o[2:0]} == {ctq_reg[15], ctq_reg[13], ctq_reg[2:0]};
  endproperty
  a_mode: assert property (p_mode) else $error("mode readback");
  property p_flags_off; rdc_reg && !ctq_reg[15] |-> rdata_o[4:3] == 2'h0; endproperty
  a_flags_off: assert property (p_flags_off) else $error("flags while off");
  property p_buf_off; rdb_reg && !ctq_reg[15] |-> rdata_o == 32'h0; endproperty
  a_buf_off: assert property (p_buf_off) else $error("buffer data while off");
  property p_irq_off; !ctl_reg[15] && !$past(ctl_reg[15]) |-> !irq_o; endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt while off");
  property p_irq_mask; msk_reg == 2'h0 && $past(msk_reg) == 2'h0 |-> !irq_o; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt while masked");
endmodule
bind icc_top icc_top_checker u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

// ---- icc_top_tb.sv ----
// testbench of the input capture channel
`timescale 1ns/1ps
`include "icc_cfg.svh"
module icc_top_tb;
  logic        clk_sys_i, rst_i, cap_pin_i, cpu_idle_i, wr_i, rd_i, irq_o;
  logic [31:0] t3, t2, tw, wdata_i, rdata_o, d;
  logic [3:0]  addr_i;
  int          miscompares, checks, cyc;
  icc_pin_model pm (.clk_sys_i(clk_sys_i), .pin_o(cap_pin_i));
  icc_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cap_pin_i(cap_pin_i), .cpu_idle_i(cpu_idle_i),
    .third_timer_source_i(t3), .second_timer_source_i(t2), .wide_timer_i(tw), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run;
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic complete_run;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // quiet gap after disable
  task automatic off;
    wr(`ICC_OFF_CTRL, 32'h0);
    wt(1);
  endtask
  // third timer holds v, second v+1111, wide v+2222_0000, while the pin moves to lv
  task automatic ed(input logic lv, input logic [31:0] v);
    @(posedge clk_sys_i);
    t3 <= v;
    t2 <= v + 32'h1111;
    tw <= v + 32'h2222_0000;
    pm.set_level(lv);
    wt(6);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(`ICC_OFF_CTRL);
    chk(d, 32'h0);
    wr(`ICC_OFF_CTRL, 32'hffff_ffff);
    rd(`ICC_OFF_CTRL);
    chk(d, 32'h0000_a3e7);
    rd(4'h2);
    chk(d, 32'h0);
    off;
    $display("test regs done");
  endtask
  task automatic t_modes;
    for (int m = 1; m < 4; m++) begin
      wr(`ICC_OFF_CTRL, 32'h0000_8000 | m);
      ed(1, 32'h1001);
      ed(0, 32'h2002);
      rd(`ICC_OFF_BUF);
      chk(d, m == 2 ? 32'h2002 : 32'h1001);
      rd(`ICC_OFF_CTRL);
      chk(d[3], m == 1);
      off;
    end
    $display("test modes done");
  endtask
  task automatic t_width;
    for (int k = 0; k < 4; k++) begin
      wr(`ICC_OFF_CTRL, 32'h0000_8003 | (k << 7));
      ed(1, 32'h1234_5678);
      ed(0, 32'h0);
      rd(`ICC_OFF_BUF);
      chk(d, k[1] ? 32'h3456_5678 : (k[0] ? 32'h6789 : 32'h5678));
      off;
    end
    $display("test width done");
  endtask
  task automatic t_ovf;
    wr(`ICC_OFF_CTRL, 32'h0000_8003);
    for (int i = 1; i < 6; i++) begin
      ed(1, i);
      ed(0, 0);
    end
    rd(`ICC_OFF_CTRL);
    chk(d[4:3], 2'h3);
    rd(`ICC_OFF_STAT);
    chk(d, 32'h3);
    for (int i = 1; i < 6; i++) begin
      rd(`ICC_OFF_BUF);
      chk(d, i < 5 ? i : 0);
    end
    rd(`ICC_OFF_CTRL);
    chk(d[4:3], 2'h2);
    off;
    rd(`ICC_OFF_CTRL);
    chk(d, 32'h0);
    $display("test overflow done");
  endtask
  task automatic t_irq;
    int nth [4] = '{2, 2, 3, 4};
    wr(`ICC_OFF_MASK, 32'h1);
    for (int n = 0; n < 4; n++) begin
      wr(`ICC_OFF_CTRL, 32'h0000_8003 | (n << 5));
      for (int i = 1; i < nth[n]; i++) begin
        ed(1, i);
        ed(0, 0);
      end
      chk(irq_o, 1'b0);
      ed(1, 0);
      ed(0, 0);
      chk(irq_o, 1'b1);
      rd(`ICC_OFF_STAT);
      chk(d, 32'h1);
      rd(`ICC_OFF_MASK);
      chk(d, 32'h1);
      wr(`ICC_OFF_MASK, 32'h0);
      wt(2);
      chk(irq_o, 1'b0);
      wr(`ICC_OFF_MASK, 32'h1);
      if (n[0]) off;
      else wr(`ICC_OFF_STAT, 32'h1);
      wt(2);
      chk(irq_o, 1'b0);
      off;
    end
    $display("test interrupt done");
  endtask
  task automatic t_first;
    for (int f = 0; f < 2; f++) begin
      wr(`ICC_OFF_CTRL, 32'h0000_8006 | (f << 9));
      ed(1, 32'h11);
      ed(0, 32'h22);
      rd(`ICC_OFF_BUF);
      chk(d, f ? 32'h11 : 32'h22);
      rd(`ICC_OFF_CTRL);
      chk(d[3], f);
      off;
    end
    $display("test first edge done");
  endtask
  task automatic t_idle;
    cpu_idle_i <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      wr(`ICC_OFF_CTRL, 32'h0000_8003 | (s << 13));
      ed(1, 5);
      ed(0, 0);
      rd(`ICC_OFF_CTRL);
      chk(d[3], !s);
      off;
    end
    cpu_idle_i <= 1'b0;
    $display("test idle done");
  endtask
  // every 4th and every 16th rising edge, two rounds each
  task automatic t_presc;
    for (int p = 4; p <= 16; p += 12) begin
      wr(`ICC_OFF_CTRL, p == 4 ? 32'h0000_8004 : 32'h0000_8005);
      for (int i = 1; i <= 2 * p; i++) begin
        ed(1, i);
        ed(0, 0);
      end
      rd(`ICC_OFF_BUF);
      chk(d, p);
      rd(`ICC_OFF_BUF);
      chk(d, 2 * p);
      rd(`ICC_OFF_CTRL);
      chk(d[4:3], 2'h0);
      off;
    end
    $display("test prescale done");
  endtask
  // mid-run reset clears registers, buffer and interrupt
  task automatic t_reset;
    wr(`ICC_OFF_MASK, 32'h1);
    wr(`ICC_OFF_CTRL, 32'h0000_8001);
    ed(1, 32'h77);
    ed(0, 32'h0);
    chk(irq_o, 1'b1);
    rst_i <= 1'b1;
    wt(2);
    chk(irq_o, 1'b0);
    chk(rdata_o, 32'h0);
    rst_i <= 1'b0;
    rd(`ICC_OFF_CTRL);
    chk(d, 32'h0);
    rd(`ICC_OFF_BUF);
    chk(d, 32'h0);
    rd(`ICC_OFF_MASK);
    chk(d, 32'h0);
    $display("test reset done");
  endtask
  // reset, then every scenario in turn
  initial begin
    {wr_i, rd_i, cpu_idle_i, addr_i, wdata_i, t3, t2, tw} = '0;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_regs;
    t_modes;
    t_width;
    t_ovf;
    t_irq;
    t_first;
    t_idle;
    t_presc;
    t_reset;
    complete_run;
  end
endmodule
